// ==== hdl/awc_pkg.sv ====
package awc_pkg;
    // Register addresses on the 8-bit special-function bus
    localparam logic [7:0] AWC_ADDR_LT_LO = 8'hC5;
    localparam logic [7:0] AWC_ADDR_LT_HI = 8'hC6;
    localparam logic [7:0] AWC_ADDR_GT_LO = 8'hC3;
    localparam logic [7:0] AWC_ADDR_GT_HI = 8'hC4;
    localparam logic [7:0] AWC_ADDR_RES_LO = 8'hBD;
    localparam logic [7:0] AWC_ADDR_RES_HI = 8'hBE;
    localparam logic [7:0] AWC_ADDR_CFG = 8'hBC;
    localparam logic [7:0] AWC_ADDR_CTL = 8'hE8;
    localparam logic [7:0] AWC_ADDR_MODE = 8'hBB;
    // Field positions
    localparam int AWC_CTL_EN = 7;
    localparam int AWC_CTL_DONE = 5;
    localparam int AWC_CTL_BUSY = 4;
    localparam int AWC_CTL_WINT = 3;
    localparam int AWC_CFG_LJST = 2;
    localparam int AWC_CFG_SC_LSB = 3;
    localparam int AWC_MODE_DIFF = 0;
    localparam int AWC_SC_W = 5;
    localparam int AWC_RES_W = 10;
    localparam int AWC_LJ_PAD = 6;
    // Reset values
    localparam logic [7:0] AWC_BYTE_RST = 8'h00;
    localparam logic [7:0] AWC_CFG_RST = 8'hF8;
    localparam logic [7:0] AWC_LT_LO_RST = 8'h00;
    // Conversion length in SAR clocks
    localparam logic [3:0] AWC_SAR_CONV_CLKS = 4'hA;

    typedef enum logic {
        AWC_ST_IDLE = 1'b0,
        AWC_ST_CONV = 1'b1
    } awc_state_e;

    // Builds the 16-bit comparison word the way the result registers hold it
    function automatic logic [15:0] awc_word(
        input logic [AWC_RES_W-1:0] r,
        input logic lj,
        input logic diff
    );
        if (lj)
            awc_word = {r, {AWC_LJ_PAD{1'b0}}};
        else if (diff)
            awc_word = {{AWC_LJ_PAD{r[AWC_RES_W-1]}}, r};
        else
            awc_word = {{AWC_LJ_PAD{1'b0}}, r};
    endfunction

    function automatic logic awc_less(
        input logic [15:0] a,
        input logic [15:0] b,
        input logic diff
    );
        awc_less = diff ? ($signed(a) < $signed(b)) : (a < b);
    endfunction
endpackage

// ==== hdl/awc_window_compare.sv ====
`timescale 1ns/1ps

// Summary of operation
// - Less-than high byte joins low byte as word
// - Less-than low byte at 0xC5, resets zero
// - Single-ended results compared as unsigned 10-bit
// - Inside window: above greater, below less limit
// - Outside window: below lower or above upper
// - Differential results and limits compared signed
// - Differential inside window uses signed compare
// - Differential outside window uses signed compare
// - Left-justified data compares identically
// - Conversion takes at least ten SAR clocks
// - Every completed result compared without software
// - Window flag sticky until software clears
// - Right-justified differential high byte sign-extends bit one
module awc_window_compare
    import awc_pkg::*;
#(
    parameter int SAR_CLKS = 10
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Special-function register bus
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    // Converter result path
    input wire logic conv_start,
    input wire logic [AWC_RES_W-1:0] conv_data,
    output logic conv_busy,
    output logic conv_done,
    // Status
    output logic window_match_flag
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] window_low_limit_lo, next_window_low_limit_lo;
    logic [7:0] window_low_limit_hi, next_window_low_limit_hi;
    logic [7:0] window_high_limit_lo, next_window_high_limit_lo;
    logic [7:0] window_high_limit_hi, next_window_high_limit_hi;
    logic [7:0] cfg, next_cfg;
    logic enable, next_enable;
    logic diff_mode, next_diff_mode;
    logic done_flag, next_done_flag;
    logic [AWC_RES_W-1:0] result, next_result;
    logic [7:0] next_sfr_rdata;
    logic next_window_match_flag;
    logic next_conv_done;
    logic next_conv_busy;
    awc_state_e state, next_state;
    logic [AWC_SC_W-1:0] div_cnt, next_div_cnt;
    logic [3:0] sar_cnt, next_sar_cnt;

    logic left_justify_select;
    logic [15:0] less_than_limit;
    logic [15:0] greater_than_limit;
    logic [15:0] res_word;
    logic [15:0] new_word;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic inside_mode;
    logic match;
    logic conv_end;
    logic sar_tick;
    logic wr_ctl;
    logic start_req;

    assign left_justify_select = cfg[AWC_CFG_LJST];
    assign less_than_limit = {window_low_limit_hi, window_low_limit_lo};
    assign greater_than_limit = {window_high_limit_hi, window_high_limit_lo};
    assign res_word = awc_word(result, left_justify_select, diff_mode);
    assign result_high_byte = res_word[15:8];
    assign result_low_byte = res_word[7:0];
    assign wr_ctl = sfr_wr && (sfr_addr == AWC_ADDR_CTL);

    ////////////////////////////////////////////////////////////////////////
    // Window decision on the word being completed
    // Limits are used as written; the format must match the converter
    assign new_word = awc_word(conv_data, left_justify_select,
        diff_mode);
    assign inside_mode = awc_less(greater_than_limit, less_than_limit,
        diff_mode);
    always_comb begin
        if (inside_mode)
            match = awc_less(greater_than_limit, new_word, diff_mode)
                && awc_less(new_word, less_than_limit,
                diff_mode);
        else
            match = awc_less(new_word, less_than_limit, diff_mode)
                || awc_less(greater_than_limit, new_word,
                diff_mode);
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    assign sar_tick = (div_cnt == cfg[7:AWC_CFG_SC_LSB]);
    assign conv_end = (state == AWC_ST_CONV) && sar_tick
        && (sar_cnt == 4'(SAR_CLKS - 1));
    assign start_req = enable && (conv_start || (wr_ctl
        && sfr_wdata[AWC_CTL_BUSY]));

    always_comb begin
        next_state = state;
        next_div_cnt = div_cnt;
        next_sar_cnt = sar_cnt;
        next_result = result;
        next_conv_done = 1'b0;
        unique case (state)
            AWC_ST_IDLE: begin
                // Starts while busy are dropped, not queued
                if (start_req) begin
                    next_state = AWC_ST_CONV;
                    next_div_cnt = '0;
                    next_sar_cnt = '0;
                end
            end
            AWC_ST_CONV: begin
                next_div_cnt = sar_tick ? '0 : div_cnt + 1'b1;
                if (sar_tick)
                    next_sar_cnt = sar_cnt + 1'b1;
                if (conv_end) begin
                    next_state = AWC_ST_IDLE;
                    next_result = conv_data;
                    next_conv_done = 1'b1;
                end
            end
        endcase
        next_conv_busy = (next_state == AWC_ST_CONV);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= AWC_ST_IDLE;
            div_cnt <= '0;
            sar_cnt <= '0;
            result <= '0;
            conv_done <= 1'b0;
            conv_busy <= 1'b0;
        end else begin
            state <= next_state;
            div_cnt <= next_div_cnt;
            sar_cnt <= next_sar_cnt;
            result <= next_result;
            conv_done <= next_conv_done;
            conv_busy <= next_conv_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file and flags
    always_comb begin
        next_window_low_limit_lo = window_low_limit_lo;
        next_window_low_limit_hi = window_low_limit_hi;
        next_window_high_limit_lo = window_high_limit_lo;
        next_window_high_limit_hi = window_high_limit_hi;
        next_cfg = cfg;
        next_enable = enable;
        next_diff_mode = diff_mode;
        next_done_flag = done_flag;
        next_window_match_flag = window_match_flag;
        if (sfr_wr) begin
            unique case (sfr_addr)
                AWC_ADDR_LT_LO: next_window_low_limit_lo = sfr_wdata;
                AWC_ADDR_LT_HI: next_window_low_limit_hi = sfr_wdata;
                AWC_ADDR_GT_LO: next_window_high_limit_lo = sfr_wdata;
                AWC_ADDR_GT_HI: next_window_high_limit_hi = sfr_wdata;
                AWC_ADDR_CFG: next_cfg = {sfr_wdata[7:AWC_CFG_LJST], 2'b00};
                AWC_ADDR_MODE: next_diff_mode = sfr_wdata[AWC_MODE_DIFF];
                AWC_ADDR_CTL: begin
                    next_enable = sfr_wdata[AWC_CTL_EN];
                    next_done_flag = sfr_wdata[AWC_CTL_DONE];
                    next_window_match_flag = sfr_wdata[AWC_CTL_WINT];
                end
                default: ;
            endcase
        end
        // A completing conversion beats a clear in the same cycle
        if (conv_end) begin
            next_done_flag = 1'b1;
            if (match)
                next_window_match_flag = 1'b1;
        end
    end

    always_comb begin
        next_sfr_rdata = AWC_BYTE_RST;
        if (sfr_rd) begin
            unique case (sfr_addr)
                AWC_ADDR_LT_LO: next_sfr_rdata = window_low_limit_lo;
                AWC_ADDR_LT_HI: next_sfr_rdata = window_low_limit_hi;
                AWC_ADDR_GT_LO: next_sfr_rdata = window_high_limit_lo;
                AWC_ADDR_GT_HI: next_sfr_rdata = window_high_limit_hi;
                AWC_ADDR_RES_LO: next_sfr_rdata = result_low_byte;
                AWC_ADDR_RES_HI: next_sfr_rdata = result_high_byte;
                AWC_ADDR_CFG: next_sfr_rdata = cfg;
                AWC_ADDR_MODE: next_sfr_rdata = {7'h00, diff_mode};
                AWC_ADDR_CTL: next_sfr_rdata = {enable, 1'b0, done_flag,
                    conv_busy, window_match_flag, 3'h0};
                default: next_sfr_rdata = AWC_BYTE_RST;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            window_low_limit_lo <= AWC_LT_LO_RST;
            window_low_limit_hi <= AWC_BYTE_RST;
            window_high_limit_lo <= AWC_BYTE_RST;
            window_high_limit_hi <= AWC_BYTE_RST;
            cfg <= AWC_CFG_RST;
            enable <= 1'b0;
            diff_mode <= 1'b0;
            done_flag <= 1'b0;
            window_match_flag <= 1'b0;
            sfr_rdata <= AWC_BYTE_RST;
        end else begin
            window_low_limit_lo <= next_window_low_limit_lo;
            window_low_limit_hi <= next_window_low_limit_hi;
            window_high_limit_lo <= next_window_high_limit_lo;
            window_high_limit_hi <= next_window_high_limit_hi;
            cfg <= next_cfg;
            enable <= next_enable;
            diff_mode <= next_diff_mode;
            done_flag <= next_done_flag;
            window_match_flag <= next_window_match_flag;
            sfr_rdata <= next_sfr_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [7:0] busy_len;
    logic [15:0] w_se;
    logic signed [15:0] w_df;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            busy_len <= '0;
        else
            busy_len <= (state == AWC_ST_CONV) ?
                8'(busy_len + (sar_tick ? 8'h01 : 8'h00)) : 8'h00;
    end
    assign w_se = {{AWC_LJ_PAD{1'b0}}, conv_data};
    assign w_df = {{AWC_LJ_PAD{conv_data[AWC_RES_W-1]}}, conv_data};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    AST_LT_LO_WRITE: assert property (
        sfr_wr && sfr_addr == AWC_ADDR_LT_LO
        |=> less_than_limit[7:0] == $past(sfr_wdata))
        else $error("less-than low byte not stored");
    AST_LT_HI_WORD: assert property (
        sfr_wr && sfr_addr == AWC_ADDR_LT_HI
        |=> less_than_limit[15:8] == $past(sfr_wdata))
        else $error("less-than high byte not in word");
    AST_CONV_LEN: assert property (
        conv_end |-> busy_len == 8'(SAR_CLKS - 1))
        else $error("conversion shorter than ten SAR clocks");
    AST_FLAG_STICKY: assert property (
        window_match_flag && !wr_ctl |=> window_match_flag)
        else $error("window flag dropped without clear");
    AST_INSIDE_SE: assert property (
        conv_end && !diff_mode && !left_justify_select
        && greater_than_limit < less_than_limit
        && w_se > greater_than_limit && w_se < less_than_limit
        |=> window_match_flag && conv_done)
        else $error("inside single-ended match missed");
    AST_OUTSIDE_SE: assert property (
        conv_end && !diff_mode && !left_justify_select
        && !(greater_than_limit < less_than_limit)
        && (w_se < less_than_limit || w_se > greater_than_limit)
        |=> window_match_flag)
        else $error("outside single-ended match missed");
    AST_INSIDE_DF: assert property (
        conv_end && diff_mode && !left_justify_select
        && $signed(greater_than_limit) < $signed(less_than_limit)
        && w_df > $signed(greater_than_limit)
        && w_df < $signed(less_than_limit)
        |=> window_match_flag)
        else $error("inside differential match missed");
    AST_SET_CAUSE: assert property (
        !window_match_flag ##1 window_match_flag
        |-> $past(conv_end && match) || $past(wr_ctl))
        else $error("window flag set without a match");
    AST_SIGN_EXT: assert property (
        !left_justify_select && diff_mode
        |-> result_high_byte[7:2] == {6{result_high_byte[1]}})
        else $error("high byte not sign-extended");
    AST_LJ_LOW: assert property (
        left_justify_select |-> result_low_byte[5:0] == 6'h00)
        else $error("left-justified low bits not zero");

    COV_INSIDE: cover property (conv_end && match && inside_mode);
    COV_OUTSIDE: cover property (conv_end && match && !inside_mode);
    COV_DIFF: cover property (conv_end && match && diff_mode);
    COV_SET_CLEAR: cover property (conv_end && match && wr_ctl);

endmodule // awc_window_compare

// ==== bench/awc_conv_src.sv ====
`timescale 1ns/1ps
module awc_conv_src
    import awc_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Converter handshake
    input wire logic conv_busy,
    input wire logic [AWC_RES_W-1:0] result_val,
    output logic [AWC_RES_W-1:0] conv_data
);
    logic [AWC_RES_W-1:0] idle_pat = 10'h155;

    // Outside a conversion the line keeps changing so a stale sample fails
    always @(posedge sys_clk) begin
        idle_pat <= ~idle_pat ^ {9'h000, idle_pat[9]};
    end

    // Result held for the whole conversion, taken at its last edge
    assign conv_data = conv_busy ? result_val : idle_pat;
endmodule // awc_conv_src

// ==== bench/adc_window_compare_tb.sv ====
`timescale 1ns/1ps
module adc_window_compare_tb;
    import awc_pkg::*;
    localparam int SAR = 10;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic conv_start = 1'b0;
    logic conv_busy, conv_done, window_match_flag;
    logic [AWC_RES_W-1:0] conv_data;
    logic [AWC_RES_W-1:0] result_val = 10'h000;
    int errors = 0;
    int num_checks = 0;
    int seed = 32'h7749;
    int exp_flag, lt_w, gt_w;
    int ltv[4] = '{128, 64, 64, -1};
    int gtv[4] = '{64, 128, -1, 64};
    int dif[4] = '{0, 0, 1, 1};

    always #20 sys_clk = ~sys_clk;

    awc_window_compare #(.SAR_CLKS(SAR)) u_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .conv_start(conv_start),
        .conv_data(conv_data), .conv_busy(conv_busy),
        .conv_done(conv_done), .window_match_flag(window_match_flag)
    );
    awc_conv_src u_src (
        .sys_clk(sys_clk), .conv_busy(conv_busy),
        .result_val(result_val), .conv_data(conv_data)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("Checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge sys_clk);
        #1;
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Limits go in with the same justification as the data
    task automatic set_limits(input int lt, input int gt, input int lj);
        lt_w = (lj != 0 ? lt << 6 : lt) & 32'hFFFF;
        gt_w = (lj != 0 ? gt << 6 : gt) & 32'hFFFF;
        wr(AWC_ADDR_LT_LO, 8'(lt_w));
        wr(AWC_ADDR_LT_HI, 8'(lt_w >> 8));
        wr(AWC_ADDR_GT_LO, 8'(gt_w));
        wr(AWC_ADDR_GT_HI, 8'(gt_w >> 8));
    endtask

    function automatic int word_of(int r, int lj, int diff);
        int v;
        v = r & 32'h3FF;
        if (lj != 0) return v << 6;
        if (diff != 0 && v >= 512) return v | 32'hFC00;
        return v;
    endfunction

    function automatic int sval(int w, int diff);
        return (diff != 0 && w >= 32'h8000) ? w - 32'h10000 : w;
    endfunction

    function automatic int match(int w, int diff);
        int r, l, g;
        r = sval(w, diff);
        l = sval(lt_w, diff);
        g = sval(gt_w, diff);
        if (l > g) return int'(r > g && r < l);
        return int'(r < l || r > g);
    endfunction

    task automatic conv(input int r, input int lj, input int diff,
            input int div, input int clr, input int sw);
        int busy_n, w;
        logic [7:0] d;
        busy_n = 0;
        w = word_of(r, lj, diff);
        if (clr != 0) begin
            wr(AWC_ADDR_CTL, 8'h80);
            exp_flag = 0;
        end
        @(posedge sys_clk);
        #1;
        result_val = 10'(r);
        if (sw != 0) begin
            // Software start through the busy bit also clears the flags
            wr(AWC_ADDR_CTL, 8'h90);
            exp_flag = 0;
        end else begin
            conv_start = 1'b1;
            @(posedge sys_clk);
            #1;
            conv_start = 1'b0;
        end
        for (int i = 0; i < 2000; i++) begin
            if (conv_done === 1'b1) break;
            if (conv_busy === 1'b1) busy_n++;
            @(posedge sys_clk);
            #1;
        end
        if (conv_done !== 1'b1) begin
            errors++;
            finish_test();
        end
        check(16'(busy_n), 16'(SAR * (div + 1)));
        exp_flag = exp_flag | match(w, diff);
        check({15'h0, window_match_flag}, 16'(exp_flag));
        rd(AWC_ADDR_RES_HI, d);
        check({8'h00, d}, 16'(w >> 8));
        rd(AWC_ADDR_RES_LO, d);
        check({8'h00, d}, 16'(w & 32'hFF));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        int k, lj, r;
        repeat (8) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        rd(AWC_ADDR_LT_LO, d);
        check({8'h00, d}, 16'h0000);
        rd(AWC_ADDR_CFG, d);
        check({8'h00, d}, 16'h00F8);
        rd(8'h00, d);
        check({8'h00, d}, 16'h0000);
        wr(AWC_ADDR_LT_LO, 8'hA5);
        wr(AWC_ADDR_LT_HI, 8'h3C);
        rd(AWC_ADDR_LT_LO, d);
        check({8'h00, d}, 16'h00A5);
        // Read data stands one cycle, then falls back to zero
        @(posedge sys_clk);
        #1;
        check({8'h00, sfr_rdata}, 16'h0000);
        rd(AWC_ADDR_LT_HI, d);
        check({8'h00, d}, 16'h003C);
        // Every window kind, both justifications, edges of each limit
        for (int j = 0; j < 8; j++) begin
            k = j / 2;
            lj = j % 2;
            wr(AWC_ADDR_CFG, lj != 0 ? 8'h04 : 8'h00);
            wr(AWC_ADDR_MODE, 8'(dif[k]));
            set_limits(ltv[k], gtv[k], lj);
            for (int p = 0; p < 8; p++) begin
                r = p < 3 ? ltv[k] + p - 1 : gtv[k] + p - 4;
                if (p > 5) r = $random(seed);
                conv(r & 32'h3FF, lj, dif[k], 0, 1, int'(p == 7));
            end
        end
        // Flag holds over a miss and clears only by a write
        wr(AWC_ADDR_CFG, 8'h08);
        wr(AWC_ADDR_MODE, 8'h00);
        set_limits(128, 64, 0);
        conv(80, 0, 0, 1, 1, 0);
        conv(16, 0, 0, 1, 0, 0);
        rd(AWC_ADDR_CTL, d);
        check({8'h00, d}, 16'h00A8);
        wr(AWC_ADDR_CTL, 8'h80);
        rd(AWC_ADDR_CTL, d);
        check({8'h00, d}, 16'h0080);
        finish_test();
    end
endmodule // adc_window_compare_tb
